/* File: csr_core.sv */
// Special-purpose core registers: control, timer, bank, pointer, PC, stack.
//
// Added by the designer: the address map and the address-and-strobe port.
module csr_core
    import csr_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Instruction core
    input  wire csr_op_t          op,
    input  wire logic [PC_W-1:0]  op_target,
    input  wire logic             pc_add,
    input  wire logic [7:0]       acc_value,
    output logic                  op_busy,
    // Pins
    input  wire logic             timer_input_pin,
    input  wire logic             ext_irq_pin_a,
    input  wire logic             ext_irq_pin_b,
    // Status outputs
    output logic      [PC_W-1:0]  pc_out,
    output logic      [BANK_BITS-1:0] bank_sel,
    output logic                  irq_enable,
    output logic                  counter_overflow_flag,
    output logic                  ext_edge_a,
    output logic                  ext_edge_b
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]             control_q;
    logic [BANK_BITS-1:0]   bank_q;
    logic [POINTER_BITS-1:0] pointer_q;

    logic [7:0]             timer_q;
    logic [7:0]             pre_q;
    logic                   ovf_q;
    logic                   tpin_q;

    logic                   pa_q;
    logic                   pb_q;
    logic                   edge_a_q;
    logic                   edge_b_q;

    logic [PC_W-1:0]        pc_q;
    logic [PC_W-1:0]        stack_q [STACK_D];
    logic [STACK_AW-1:0]    sp_q;

    logic [7:0]             data_q [64];
    logic [7:0]             rdata_q;

    csr_state_t             state_q;
    logic [PC_W-1:0]        hold_q;
    logic                   hold_call_q;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire       hit_ind   = reg_addr == ADDR_INDIRECT;
    wire       hit_bank  = reg_addr == ADDR_BANK;
    wire       hit_pc    = reg_addr == ADDR_PC;
    wire       hit_ptr   = reg_addr == ADDR_POINTER;
    wire       hit_ctl   = reg_addr == ADDR_CONTROL;
    wire       hit_stat  = reg_addr == ADDR_STATUS;
    wire       hit_tmr   = reg_addr == ADDR_TIMER;
    wire       hit_pchi  = reg_addr == ADDR_PC_HI;
    wire       hit_data  = (reg_addr <= ADDR_DATA_LAST) && !hit_ind
                           && !hit_bank && !hit_pc && !hit_ptr;

    // Indirect accesses go to the location held in the pointer.
    wire [5:0] data_idx  = hit_ind ? pointer_q : reg_addr[5:0];
    wire       data_wr   = reg_wr && (hit_ind || hit_data);

    // An indirect access that points back at a special register is dropped.
    wire       ind_spec  = pointer_q <= 6'h04;

    // ------------------------------------------------------------------
    // Timer tick selection
    // ------------------------------------------------------------------
    wire       src_ext   = control_q[CTL_SRC];
    wire       pin_rise  = timer_input_pin && !tpin_q;
    wire       pin_fall  = !timer_input_pin && tpin_q;
    wire       ext_tick  = control_q[CTL_EDGE] ? pin_fall : pin_rise;
    wire       src_tick  = src_ext ? ext_tick : 1'b1;
    wire [2:0] ratio     = control_q[CTL_RATIO_HI:0];

    // Ratio code n divides by 2^(n+1).
    wire [7:0] pre_mask  = 8'((9'h002 << ratio) - 9'h001);
    wire       pre_done  = (pre_q & pre_mask) == pre_mask;
    wire       tmr_tick  = src_tick
                           && (!control_q[CTL_PRE_EN] || pre_done);
    wire       tmr_wrap  = tmr_tick && (timer_q == 8'hff);

    wire       ovf_clr   = reg_wr && hit_stat && !reg_wdata[0];

    // ------------------------------------------------------------------
    // External interrupt edges
    // ------------------------------------------------------------------
    wire       fall_sel  = control_q[CTL_EXT_EDGE];
    wire       a_edge    = fall_sel ? (pa_q && !ext_irq_pin_a)
                                    : (!pa_q && ext_irq_pin_a);
    wire       b_edge    = fall_sel ? (pb_q && !ext_irq_pin_b)
                                    : (!pb_q && ext_irq_pin_b);

    // ------------------------------------------------------------------
    // Program counter next value
    // ------------------------------------------------------------------
    wire [PC_W-1:0]     pc_inc  = pc_q + 11'h001;
    wire [PC_W-1:0]     top     = stack_q[sp_q - 3'h1];

    wire                pc_wr   = reg_wr && hit_pc;
    wire                pop     = (op == OP_RETURN) || (op == OP_RETURN_LIT)
                                  || (op == OP_RETURN_IRQ);
    wire                push    = (op == OP_CALL) || (op == OP_TAKE_IRQ);
    wire                lng     = (op == OP_LONG_JUMP)
                                  || (op == OP_LONG_CALL);
    wire                ready   = state_q == ST_READY;
    wire                op_ok   = ready && !pc_add && !pc_wr;

    logic [PC_W-1:0]    pc_d;

    always_comb
    begin
        pc_d = pc_q;
        if (state_q == ST_SECOND)
            pc_d = hold_q;
        else if (pc_add)
            pc_d = pc_q + {3'h0, acc_value};
        else if (pc_wr)
            pc_d = {pc_q[PC_W-1:8], reg_wdata};
        else
            case (op)
                OP_JUMP, OP_CALL:
                    pc_d = {pc_q[PC_W-1], op_target[PAGE_BITS-1:0]};
                OP_TAKE_IRQ:
                    pc_d = op_target;
                OP_RETURN, OP_RETURN_LIT, OP_RETURN_IRQ:
                    pc_d = top;
                OP_NEXT, OP_ENABLE_IRQ, OP_DISABLE_IRQ:
                    pc_d = pc_inc;
                default:
                    pc_d = pc_q;
            endcase
    end

    // ------------------------------------------------------------------
    // Control, bank and pointer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            control_q <= CONTROL_RESET;
            bank_q    <= BANK_RESET[BANK_BITS-1:0];
            pointer_q <= 6'h00;
        end
        else
        begin
            if (reg_wr && hit_ctl)
            begin
                control_q[7]   <= reg_wdata[7];
                control_q[5:0] <= reg_wdata[5:0];
            end

            if (op_ok && (op == OP_DISABLE_IRQ || op == OP_TAKE_IRQ))
                control_q[CTL_GIE] <= 1'b0;
            else if (op_ok && (op == OP_ENABLE_IRQ || op == OP_RETURN_IRQ))
                control_q[CTL_GIE] <= 1'b1;

            if (reg_wr && hit_bank)
                bank_q <= reg_wdata[BANK_BITS-1:0];
            if (reg_wr && hit_ptr)
                pointer_q <= reg_wdata[POINTER_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Timer, prescaler and overflow flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timer_q <= 8'h00;
            pre_q   <= 8'h00;
            ovf_q   <= 1'b0;
            tpin_q  <= 1'b0;
        end
        else
        begin
            tpin_q <= timer_input_pin;
            if (reg_wr && hit_tmr)
            begin
                timer_q <= reg_wdata;
                pre_q   <= 8'h00;
            end
            else
            begin
                if (src_tick)
                    pre_q <= pre_done ? 8'h00 : pre_q + 8'h01;
                if (tmr_tick)
                    timer_q <= timer_q + 8'h01;
            end

            // A new overflow wins over a clear in the same cycle.
            if (tmr_wrap)
                ovf_q <= 1'b1;
            else if (ovf_clr)
                ovf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // External pins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pa_q     <= 1'b0;
            pb_q     <= 1'b0;
            edge_a_q <= 1'b0;
            edge_b_q <= 1'b0;
        end
        else
        begin
            pa_q     <= ext_irq_pin_a;
            pb_q     <= ext_irq_pin_b;
            edge_a_q <= a_edge;
            edge_b_q <= b_edge;
        end
    end

    // ------------------------------------------------------------------
    // Program counter, stack and two-cycle sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pc_q        <= PC_RESET;
            sp_q        <= '0;
            state_q     <= ST_READY;
            hold_q      <= PC_RESET;
            hold_call_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            case (state_q)
                ST_READY:
                    if (lng && op_ok)
                    begin
                        state_q     <= ST_SECOND;
                        hold_q      <= op_target;
                        hold_call_q <= op == OP_LONG_CALL;
                        pc_q        <= pc_q;
                    end
                ST_SECOND:
                    state_q <= ST_READY;
                default:
                    state_q <= ST_READY;
            endcase

            // The pointer wraps so the oldest entry is overwritten.
            if (op_ok && push)
                sp_q <= sp_q + 3'h1;
            else if (state_q == ST_SECOND && hold_call_q)
                sp_q <= sp_q + 3'h1;
            else if (op_ok && pop)
                sp_q <= sp_q - 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (op_ok && push)
            stack_q[sp_q] <= (op == OP_TAKE_IRQ) ? pc_q : pc_inc;
        else if (state_q == ST_SECOND && hold_call_q)
            stack_q[sp_q] <= pc_inc;
    end

    // ------------------------------------------------------------------
    // General data locations, banked from 20h up
    // ------------------------------------------------------------------
    wire [5:0] bank_idx = data_idx;
    wire       banked   = bank_idx[5] && bank_q[0];

    logic [7:0] data_hi [32];

    always_ff @(posedge clk)
    begin
        if (data_wr && !(hit_ind && ind_spec))
        begin
            if (banked)
                data_hi[bank_idx[4:0]] <= reg_wdata;
            else
                data_q[bank_idx] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read path; the accumulator has no address
    // ------------------------------------------------------------------
    wire [7:0] stat_val = {7'h00, ovf_q};
    wire [7:0] data_val = banked ? data_hi[bank_idx[4:0]] : data_q[bank_idx];

    wire [7:0] rd_mux   =
        hit_ctl  ? control_q :
        hit_bank ? {6'h00, bank_q} :
        hit_pc   ? pc_q[7:0] :
        hit_pchi ? {5'h00, pc_q[PC_W-1:8]} :
        hit_ptr  ? {2'h0, pointer_q} :
        hit_stat ? stat_val :
        hit_tmr  ? timer_q :
        (hit_ind && ind_spec) ? 8'h00 :
        (hit_ind || hit_data) ? data_val :
        8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 8'h00;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata             = rdata_q;
    assign pc_out                = pc_q;
    assign bank_sel              = bank_q;
    assign irq_enable            = control_q[CTL_GIE];
    assign counter_overflow_flag = ovf_q;
    assign ext_edge_a            = edge_a_q;
    assign ext_edge_b            = edge_b_q;
    assign op_busy               = state_q == ST_SECOND;

endmodule

/* File: csr_core_properties.sv */
// Concurrent checks on the ports of the core special registers block.
module csr_core_properties
    import csr_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    // Instruction core and status
    input wire csr_op_t              op,
    input wire logic [PC_W-1:0]      op_target,
    input wire logic                 pc_add,
    input wire logic [7:0]           acc_value,
    input wire logic                 op_busy,
    input wire logic [PC_W-1:0]      pc_out,
    input wire logic [BANK_BITS-1:0] bank_sel,
    input wire logic                 irq_enable,
    input wire logic                 counter_overflow_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // An op only counts when no PC write or add overrides it.
    wire logic            pc_wr   = reg_wr && reg_addr == ADDR_PC;
    wire logic            op_live = !op_busy && !pc_add && !pc_wr;
    wire logic            long_op = op == OP_LONG_JUMP || op == OP_LONG_CALL;
    wire logic [PC_W-1:0] jump_pc = {pc_out[PC_W-1], op_target[9:0]};
    wire logic [PC_W-1:0] add_pc  = pc_out + {3'h0, acc_value};
    wire logic [PC_W-1:0] low_pc  = {pc_out[PC_W-1:8], reg_wdata};
    wire logic [1:0]      wbank   = reg_wdata[1:0];

    chk_reset_pc: assert property ($past(rst) |-> pc_out == PC_RESET)
        else $error("pc not clear after reset");
    chk_pc_next: assert property (op == OP_NEXT && op_live
        |=> pc_out == $past(pc_out) + 11'h001)
        else $error("pc did not advance by one");
    chk_jump_page: assert property (op == OP_JUMP && op_live
        |=> pc_out == $past(jump_pc))
        else $error("short jump target wrong");
    chk_long_busy: assert property (long_op && op_live
        |=> op_busy ##1 (!op_busy && pc_out == $past(op_target, 2)))
        else $error("long transfer timing or target wrong");
    chk_busy_once: assert property (op_busy |=> !op_busy)
        else $error("busy longer than one cycle");
    chk_add_carry: assert property (pc_add && !op_busy
        |=> pc_out == $past(add_pc))
        else $error("pc add wrong");
    chk_pc_low: assert property (pc_wr && !pc_add && !op_busy
        |=> pc_out == $past(low_pc))
        else $error("pc write touched upper bits");
    chk_ie_clear: assert property ((op == OP_DISABLE_IRQ
        || op == OP_TAKE_IRQ) && op_live |=> !irq_enable)
        else $error("irq enable not cleared");
    chk_ie_set: assert property ((op == OP_ENABLE_IRQ
        || op == OP_RETURN_IRQ) && op_live |=> irq_enable)
        else $error("irq enable not set");
    chk_bank_sel: assert property (reg_wr && reg_addr == ADDR_BANK
        |=> bank_sel == $past(wbank))
        else $error("bank select not loaded");
    chk_bank_high: assert property (reg_rd && reg_addr == ADDR_BANK
        |=> reg_rdata[7:2] == 6'h00)
        else $error("bank upper bits not zero");
    chk_ptr_high: assert property (reg_rd && reg_addr == ADDR_POINTER
        |=> reg_rdata[7:6] == 2'h0)
        else $error("pointer upper bits not zero");
    chk_flag_hold: assert property (counter_overflow_flag
        && !(reg_wr && reg_addr == ADDR_STATUS) |=> counter_overflow_flag)
        else $error("overflow flag dropped");

    cov_long_call: cover property (op == OP_LONG_CALL && op_live);
    cov_pc_add: cover property (pc_add && !op_busy);
    cov_overflow: cover property ($rose(counter_overflow_flag));
    cov_ret_irq: cover property (op == OP_RETURN_IRQ && op_live);
endmodule

bind csr_core csr_core_properties csr_core_properties_inst (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op,
    .op_target, .pc_add, .acc_value, .op_busy, .pc_out, .bank_sel,
    .irq_enable, .counter_overflow_flag
);

/* File: csr_pkg.sv */
// Constants, offsets and types for the core special registers block.
package csr_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_INDIRECT  = 8'h00;
    localparam logic [7:0] ADDR_BANK      = 8'h01;
    localparam logic [7:0] ADDR_PC        = 8'h02;
    localparam logic [7:0] ADDR_POINTER   = 8'h04;
    localparam logic [7:0] ADDR_CONTROL   = 8'h40;
    localparam logic [7:0] ADDR_STATUS    = 8'h41;
    localparam logic [7:0] ADDR_TIMER     = 8'h42;
    localparam logic [7:0] ADDR_PC_HI     = 8'h43;
    localparam logic [7:0] ADDR_DATA_LAST = 8'h3f;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTL_EXT_EDGE   = 7;
    localparam int CTL_GIE        = 6;
    localparam int CTL_SRC        = 5;
    localparam int CTL_EDGE       = 4;
    localparam int CTL_PRE_EN     = 3;
    localparam int CTL_RATIO_HI   = 2;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET    = 8'h00;
    localparam int BANK_BITS      = 2;
    localparam int POINTER_BITS   = 6;

    // ------------------------------------------------------------------
    // Program counter and stack
    // ------------------------------------------------------------------
    localparam int PC_W       = 11;
    localparam int PAGE_BITS  = 10;
    localparam int STACK_D    = 8;
    localparam int STACK_AW   = 3;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;

    // Oscillator clocks per instruction cycle.
    localparam int OSC_PER_CYCLE = 2;

    // ------------------------------------------------------------------
    // Flow-control operations issued by the instruction core
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_NEXT,
        OP_JUMP,
        OP_CALL,
        OP_LONG_JUMP,
        OP_LONG_CALL,
        OP_RETURN,
        OP_RETURN_LIT,
        OP_RETURN_IRQ,
        OP_ENABLE_IRQ,
        OP_DISABLE_IRQ,
        OP_TAKE_IRQ
    } csr_op_t;

    typedef enum logic [0:0] {
        ST_READY,
        ST_SECOND
    } csr_state_t;

endpackage

/* File: tb.sv */
// Self-checking bench for the core special registers block.
module tb
    import csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Design ports and bench state
    // ------------------------------------------------------------------
    logic                 clk, rst, reg_wr, reg_rd, pc_add, op_busy;
    logic      [7:0]      reg_addr, reg_wdata, reg_rdata, acc_value;
    csr_op_t              op;
    logic      [PC_W-1:0] op_target, pc_out, pc_m;
    logic                 timer_input_pin, ext_irq_pin_a, ext_irq_pin_b;
    logic [BANK_BITS-1:0] bank_sel;
    logic                 irq_enable, counter_overflow_flag;
    logic                 ext_edge_a, ext_edge_b, ie_m;
    logic                 rd_pend = 1'b0;
    logic      [PC_W-1:0] stk[$];
    logic      [7:0]      exp_q[$];
    logic      [31:0]     v;
    integer               seed = 32'h85c1845a;
    int                   fail_count = 0, n_checks = 0, cyc = 0;
    int                   na = 0, nb = 0, a0, b0;
    csr_op_t              irq_ops[4] = '{OP_TAKE_IRQ, OP_ENABLE_IRQ,
                                         OP_DISABLE_IRQ, OP_RETURN_IRQ};

    csr_core csr_core_inst (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .op, .op_target, .pc_add, .acc_value, .op_busy, .timer_input_pin,
        .ext_irq_pin_a, .ext_irq_pin_b, .pc_out, .bank_sel, .irq_enable,
        .counter_overflow_flag, .ext_edge_a, .ext_edge_b
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d, input csr_op_t o = OP_NONE,
                        input logic [PC_W-1:0] t = '0, input logic pa = 1'b0);
        @(posedge clk);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        op        <= o;
        op_target <= t;
        pc_add    <= pa;
    endtask

    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1'b1, 1'b0, a, d);
    endtask

    // A read notes its expected byte; the monitor compares it a cycle on.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        step(1'b0, 1'b1, a, 8'h00);
        exp_q.push_back(e);
    endtask

    task automatic chk_pc();
        rd(ADDR_PC, pc_m[7:0]);
        rd(ADDR_PC_HI, {5'h00, pc_m[10:8]});
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        idle(20);
        rst <= 1'b0;
        pc_m = PC_RESET;
        ie_m = 1'b0;
        stk.delete();
    endtask

    task automatic do_op(input csr_op_t o, input logic [PC_W-1:0] t);
        step(1'b0, 1'b0, 8'h00, 8'h00, o, t);
        if (o == OP_CALL || o == OP_LONG_CALL || o == OP_TAKE_IRQ)
            stk.push_back(o == OP_TAKE_IRQ ? pc_m : pc_m + 11'h001);
        if (stk.size() > STACK_D)
            void'(stk.pop_front());
        case (o)
            OP_NEXT, OP_ENABLE_IRQ,
            OP_DISABLE_IRQ:              pc_m = pc_m + 11'h001;
            OP_JUMP, OP_CALL:            pc_m = {pc_m[10], t[9:0]};
            OP_LONG_JUMP, OP_LONG_CALL:  pc_m = t;
            OP_TAKE_IRQ:                 pc_m = t;
            OP_RETURN, OP_RETURN_LIT,
            OP_RETURN_IRQ:               pc_m = stk.pop_back();
            default:                     ;
        endcase
        if (o == OP_ENABLE_IRQ || o == OP_RETURN_IRQ)
            ie_m = 1'b1;
        if (o == OP_DISABLE_IRQ || o == OP_TAKE_IRQ)
            ie_m = 1'b0;
        if (o == OP_LONG_JUMP || o == OP_LONG_CALL)
            step(1'b0, 1'b0, 8'h00, 8'h00, OP_NEXT);
    endtask

    // Loads the timer 16 counts short of overflow and probes the flag.
    task automatic tmr(input logic [7:0] ctl, input int ticks);
        wr(ADDR_CONTROL, ctl);
        wr(ADDR_TIMER, 8'hf0);
        wr(ADDR_STATUS, 8'h00);
        idle(ticks - 4);
        rd(ADDR_STATUS, 8'h00);
        idle(6);
        rd(ADDR_STATUS, 8'h01);
        idle(3);
        rd(ADDR_STATUS, 8'h01);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Monitor and cycle limit
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rd_pend)
            cmp(reg_rdata, exp_q.pop_front());
        rd_pend <= reg_rd && !rst;
        na      <= na + int'(ext_edge_a === 1'b1);
        nb      <= nb + int'(ext_edge_b === 1'b1);
        cyc     <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        {reg_wr, reg_rd, pc_add, timer_input_pin} = 4'h0;
        {ext_irq_pin_a, ext_irq_pin_b} = 2'b00;
        {reg_addr, reg_wdata, acc_value} = 24'h000000;
        op = OP_NONE;
        op_target = 11'h000;
        do_reset();
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_BANK, BANK_RESET);
        chk_pc();
        wr(ADDR_CONTROL, 8'hff);
        rd(ADDR_CONTROL, 8'hbf);
        wr(8'h80, 8'hff);
        rd(8'h80, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            wr(ADDR_BANK, v[7:0]);
            rd(ADDR_BANK, {6'h00, v[1:0]});
            wr(ADDR_POINTER, v[15:8]);
            rd(ADDR_POINTER, {2'h0, v[13:8]});
        end
        wr(ADDR_BANK, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            v[7:0] = 8'h05 + v[7:0] % 8'd59;
            wr(ADDR_POINTER, v[7:0]);
            wr(ADDR_INDIRECT, v[15:8]);
            rd(v[7:0], v[15:8]);
            wr(v[7:0], v[23:16]);
            rd(ADDR_INDIRECT, v[23:16]);
        end
        wr(8'h28, 8'h5a);
        wr(ADDR_BANK, 8'h01);
        wr(8'h28, 8'ha5);
        rd(8'h28, 8'ha5);
        wr(ADDR_BANK, 8'h00);
        rd(8'h28, 8'h5a);
        $display("test registers finished");
        tmr(8'h00, 16);
        for (int k = 0; k < 8; k++)
            tmr(8'h08 | 8'(k), 16 << (k + 1));
        for (int e = 0; e < 2; e++)
        begin
            timer_input_pin <= ~e[0];
            idle(3);
            wr(ADDR_CONTROL, {3'b001, e[0], 4'h0});
            wr(ADDR_TIMER, 8'hff);
            wr(ADDR_STATUS, 8'h00);
            timer_input_pin <= e[0];
            idle(4);
            rd(ADDR_STATUS, 8'h00);
            timer_input_pin <= ~e[0];
            idle(4);
            rd(ADDR_STATUS, 8'h01);
        end
        for (int e = 0; e < 2; e++)
        begin
            wr(ADDR_CONTROL, {e[0], 7'h00});
            idle(3);
            a0 = na;
            b0 = nb;
            {ext_irq_pin_a, ext_irq_pin_b} <= 2'b11;
            idle(5);
            cmp(8'(na - a0), 8'(1 - e));
            cmp(8'(nb - b0), 8'(1 - e));
            {ext_irq_pin_a, ext_irq_pin_b} <= 2'b00;
            idle(5);
            cmp(8'(na - a0), 8'h01);
            cmp(8'(nb - b0), 8'h01);
        end
        $display("test timer and edges finished");
        wr(ADDR_CONTROL, 8'h00);
        repeat (3) do_op(OP_NEXT, 11'h000);
        chk_pc();
        do_op(OP_JUMP, 11'h7ff);
        chk_pc();
        do_op(OP_LONG_JUMP, 11'h4f0);
        chk_pc();
        do_op(OP_JUMP, 11'h123);
        do_op(OP_CALL, 11'h0ff);
        do_op(OP_LONG_CALL, 11'h0a0);
        chk_pc();
        do_op(OP_RETURN_LIT, 11'h000);
        chk_pc();
        do_op(OP_RETURN, 11'h000);
        chk_pc();
        for (int i = 0; i < 9; i++)
        begin
            v = $random(seed);
            do_op(OP_LONG_CALL, v[10:0]);
        end
        chk_pc();
        repeat (8) do_op(OP_RETURN, 11'h000);
        chk_pc();
        do_op(OP_LONG_JUMP, 11'h0fe);
        for (int i = 0; i < 3; i++)
        begin
            v = $random(seed);
            acc_value <= v[7:0];
            step(1'b0, 1'b0, 8'h00, 8'h00, OP_NEXT, 11'h000, 1'b1);
            pc_m = pc_m + {3'h0, v[7:0]};
            chk_pc();
        end
        wr(ADDR_PC, 8'h11);
        pc_m = {pc_m[10:8], 8'h11};
        chk_pc();
        foreach (irq_ops[i])
        begin
            do_op(irq_ops[i], 11'h004);
            rd(ADDR_CONTROL, {1'b0, ie_m, 6'h00});
            chk_pc();
        end
        chk_pc();
        do_op(OP_LONG_JUMP, 11'h3c5);
        do_reset();
        chk_pc();
        idle(3);
        $display("test program counter finished");
        close_out();
    end
endmodule
